// *** rtl/sstt_map.vh ***
// Register offsets, field positions and reset values of the shift/sub/test/trap/translate datapath
`ifndef SSTT_MAP_VH
`define SSTT_MAP_VH
`define SSTT_OFS_CTRL 8'h00
`define SSTT_OFS_DEST 8'h04
`define SSTT_OFS_SRC 8'h08
`define SSTT_OFS_EXT 8'h0C
`define SSTT_OFS_FCW 8'h10
`define SSTT_OFS_RESULT 8'h14
`define SSTT_OFS_STATUS 8'h18
`define SSTT_OFS_SP 8'h1C
`define SSTT_OFS_COUNT 8'h20
`define SSTT_OFS_PC 8'h24
`define SSTT_CTRL_OP_LSB 0
`define SSTT_CTRL_SIZE_LSB 4
`define SSTT_CTRL_MODE_LSB 8
`define SSTT_CTRL_CC_LSB 12
`define SSTT_OP_SHIFT_RIGHT 4'h0
`define SSTT_OP_SUBTRACT 4'h1
`define SSTT_OP_COND_BIT_SET 4'h2
`define SSTT_OP_LOGICAL_TEST 4'h3
`define SSTT_OP_ARITH_TEST 4'h4
`define SSTT_OP_COND_TRAP 4'h5
`define SSTT_OP_TRANSLATE 4'h6
`define SSTT_SIZE_BYTE 2'h0
`define SSTT_SIZE_WORD 2'h1
`define SSTT_SIZE_LONG 2'h2
`define SSTT_MODE_COMPACT 2'h0
`define SSTT_MODE_SEGMENTED 2'h1
`define SSTT_MODE_LINEAR 2'h2
`define SSTT_FLAG_C 7
`define SSTT_FLAG_Z 6
`define SSTT_FLAG_S 5
`define SSTT_FLAG_PV 4
`define SSTT_FLAG_D 3
`define SSTT_FLAG_H 2
`define SSTT_STAT_BUSY 0
`define SSTT_STAT_OVF_TRAP 1
`define SSTT_STAT_TRAP_TAKEN 2
`define SSTT_STAT_BAD_COUNT 3
`define SSTT_STAT_CAUSE_LSB 4
`define SSTT_RST_WORD 32'h00000000
`define SSTT_RST_FCW 16'h0000
`define SSTT_TRAP_PS_ADDR 32'h00000000
`endif

// *** rtl/sstt_core.v ***
// Shift/subtract/test/trap/translate datapath with Avalon-MM register slave and memory port
`timescale 1ns/1ps
`include "sstt_map.vh"

module sstt_core #(
  parameter [31:0] TRAP_PS_ADDR = `SSTT_TRAP_PS_ADDR
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Avalon-MM slave
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  // Memory access path
  output reg o_mem_req,
  output reg o_mem_we,
  output reg [31:0] o_mem_addr,
  output reg [31:0] o_mem_wdata,
  output reg [1:0] o_mem_size,
  input wire i_mem_ack,
  input wire [31:0] i_mem_rdata,
  // Status toward the core
  output wire o_busy,
  output reg o_ovf_trap,
  output reg o_trap_taken,
  output reg [3:0] o_trap_cause
);

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_EXEC = 4'h1;
  localparam [3:0] ST_TR_RD_TGT = 4'h2;
  localparam [3:0] ST_TR_RD_TAB = 4'h3;
  localparam [3:0] ST_TR_WR = 4'h4;
  localparam [3:0] ST_TP_PUSH_FCW = 4'h5;
  localparam [3:0] ST_TP_PUSH_PC = 4'h6;
  localparam [3:0] ST_TP_PUSH_INS = 4'h7;
  localparam [3:0] ST_TP_LOAD = 4'h8;

  reg [15:0] ctrl;
  reg [31:0] dest;
  reg [31:0] src;
  reg [31:0] ext;
  reg [15:0] flag_control_word;
  reg [31:0] result;
  reg [31:0] sp;
  reg [15:0] count;
  reg [31:0] pc;
  reg [3:0] state;
  reg ack;
  reg stat_ovf;
  reg stat_trap;
  reg stat_bad;
  reg [7:0] tgt_byte;
  reg [7:0] xlat_byte;

  wire [3:0] op = ctrl[`SSTT_CTRL_OP_LSB +: 4];
  wire [1:0] size = ctrl[`SSTT_CTRL_SIZE_LSB +: 2];
  wire [1:0] mode = ctrl[`SSTT_CTRL_MODE_LSB +: 2];
  wire [3:0] cc = ctrl[`SSTT_CTRL_CC_LSB +: 4];

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function [31:0] mask_sz;
    input [31:0] v;
    input [1:0] s;
    begin
      case (s)
        `SSTT_SIZE_BYTE: mask_sz = {24'h000000, v[7:0]};
        `SSTT_SIZE_WORD: mask_sz = {16'h0000, v[15:0]};
        default: mask_sz = v;
      endcase
    end
  endfunction

  function msb_sz;
    input [31:0] v;
    input [1:0] s;
    begin
      case (s)
        `SSTT_SIZE_BYTE: msb_sz = v[7];
        `SSTT_SIZE_WORD: msb_sz = v[15];
        default: msb_sz = v[31];
      endcase
    end
  endfunction

  // Segmented offsets wrap inside their segment
  function [31:0] addr_add;
    input [31:0] base;
    input [31:0] off;
    input [1:0] m;
    reg [31:0] sum;
    begin
      sum = base + off;
      case (m)
        `SSTT_MODE_COMPACT: addr_add = {16'h0000, sum[15:0]};
        `SSTT_MODE_SEGMENTED: addr_add = {base[31:16], sum[15:0]};
        default: addr_add = sum;
      endcase
    end
  endfunction

  function cond_met;
    input [3:0] c;
    input [15:0] f;
    reg fc, fz, fs, fv;
    begin
      fc = f[`SSTT_FLAG_C];
      fz = f[`SSTT_FLAG_Z];
      fs = f[`SSTT_FLAG_S];
      fv = f[`SSTT_FLAG_PV];
      case (c)
        4'h0: cond_met = 1'b0;
        4'h1: cond_met = fs ^ fv;
        4'h2: cond_met = fz | (fs ^ fv);
        4'h3: cond_met = fc | fz;
        4'h4: cond_met = fv;
        4'h5: cond_met = fs;
        4'h6: cond_met = fz;
        4'h7: cond_met = fc;
        4'h8: cond_met = 1'b1;
        4'h9: cond_met = ~(fs ^ fv);
        4'hA: cond_met = ~(fz | (fs ^ fv));
        4'hB: cond_met = ~(fc | fz);
        4'hC: cond_met = ~fv;
        4'hD: cond_met = ~fs;
        4'hE: cond_met = ~fz;
        default: cond_met = ~fc;
      endcase
    end
  endfunction

  function [31:0] merge_be;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer k;
    begin
      merge_be = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          merge_be[8*k +: 8] = nw[8*k +: 8];
        end
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Single-cycle arithmetic

  wire [31:0] opd = mask_sz(dest, size);
  wire [31:0] ops = mask_sz(src, size);
  wire [15:0] neg_cnt = (size == `SSTT_SIZE_BYTE) ? {8'h00, 8'h00 - ext[7:0]} : 16'h0000 - ext[15:0];
  wire cnt_neg = (size == `SSTT_SIZE_BYTE) ? ext[7] : ext[15];
  wire [32:0] shf = {opd, 1'b0} >> neg_cnt;
  wire [31:0] shf_res = shf[32:1];
  wire [32:0] diff = {1'b0, opd} - {1'b0, ops};
  wire [31:0] sub_res = mask_sz(diff[31:0], size);
  wire sub_borrow = (size == `SSTT_SIZE_BYTE) ? diff[8] : (size == `SSTT_SIZE_WORD) ? diff[16] : diff[32];
  wire [4:0] nib = {1'b0, opd[3:0]} - {1'b0, ops[3:0]};
  wire sub_ovf = (msb_sz(opd, size) != msb_sz(ops, size)) && (msb_sz(sub_res, size) == msb_sz(ops, size));
  wire cc_ok = cond_met(cc, flag_control_word);
  wire [15:0] count_dec = count - 16'h0001;
  wire [31:0] fcw_wr = merge_be({16'h0000, flag_control_word}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] count_wr = merge_be({16'h0000, count}, i_avs_writedata, i_avs_byteenable);
  wire [31:0] dest_dec = addr_add(dest, 32'hFFFFFFFF, mode);
  wire [31:0] trap_sp = sp - 32'h00000006;
  wire [31:0] ins_sp = sp - 32'h00000008;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle per access, writes held while busy

  wire req = i_avs_read | i_avs_write;
  wire bus_wr = i_avs_write & ack;
  wire ofs_ok = (i_avs_address[1:0] == 2'h0);
  assign o_avs_waitrequest = req & ~ack;
  assign o_busy = (state != ST_IDLE);

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ack <= 1'b0;
      o_avs_readdata <= `SSTT_RST_WORD;
    end else begin
      ack <= req & ~ack & ~(i_avs_write & o_busy);
      if (i_avs_read & ~ack) begin
        o_avs_readdata <= `SSTT_RST_WORD;
        if (ofs_ok) begin
          case (i_avs_address)
            `SSTT_OFS_CTRL: o_avs_readdata <= {16'h0000, ctrl};
            `SSTT_OFS_DEST: o_avs_readdata <= dest;
            `SSTT_OFS_SRC: o_avs_readdata <= src;
            `SSTT_OFS_EXT: o_avs_readdata <= ext;
            `SSTT_OFS_FCW: o_avs_readdata <= {16'h0000, flag_control_word};
            `SSTT_OFS_RESULT: o_avs_readdata <= result;
            `SSTT_OFS_STATUS: o_avs_readdata <= {24'h000000, o_trap_cause, stat_bad, stat_trap, stat_ovf, o_busy};
            `SSTT_OFS_SP: o_avs_readdata <= sp;
            `SSTT_OFS_COUNT: o_avs_readdata <= {16'h0000, count};
            `SSTT_OFS_PC: o_avs_readdata <= pc;
            default: o_avs_readdata <= `SSTT_RST_WORD;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and architectural state

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= 16'h0000;
      dest <= `SSTT_RST_WORD;
      src <= `SSTT_RST_WORD;
      ext <= `SSTT_RST_WORD;
      flag_control_word <= `SSTT_RST_FCW;
      result <= `SSTT_RST_WORD;
      sp <= `SSTT_RST_WORD;
      count <= 16'h0000;
      pc <= `SSTT_RST_WORD;
      state <= ST_IDLE;
      stat_ovf <= 1'b0;
      stat_trap <= 1'b0;
      stat_bad <= 1'b0;
      tgt_byte <= 8'h00;
      xlat_byte <= 8'h00;
      o_mem_req <= 1'b0;
      o_mem_we <= 1'b0;
      o_mem_addr <= `SSTT_RST_WORD;
      o_mem_wdata <= `SSTT_RST_WORD;
      o_mem_size <= 2'h0;
      o_ovf_trap <= 1'b0;
      o_trap_taken <= 1'b0;
      o_trap_cause <= 4'h0;
    end else begin
      o_ovf_trap <= 1'b0;
      o_trap_taken <= 1'b0;
      if (bus_wr && ofs_ok && state == ST_IDLE) begin
        case (i_avs_address)
          `SSTT_OFS_CTRL: begin
            ctrl <= i_avs_writedata[15:0];
            stat_ovf <= 1'b0;
            stat_trap <= 1'b0;
            stat_bad <= 1'b0;
            state <= ST_EXEC;
          end
          `SSTT_OFS_DEST: dest <= merge_be(dest, i_avs_writedata, i_avs_byteenable);
          `SSTT_OFS_SRC: src <= merge_be(src, i_avs_writedata, i_avs_byteenable);
          `SSTT_OFS_EXT: ext <= merge_be(ext, i_avs_writedata, i_avs_byteenable);
          `SSTT_OFS_FCW: flag_control_word <= fcw_wr[15:0];
          `SSTT_OFS_SP: sp <= merge_be(sp, i_avs_writedata, i_avs_byteenable);
          `SSTT_OFS_COUNT: count <= count_wr[15:0];
          `SSTT_OFS_PC: pc <= merge_be(pc, i_avs_writedata, i_avs_byteenable);
          default: ;
        endcase
      end
      case (state)
        ST_IDLE: ;
        ST_EXEC: begin
          state <= ST_IDLE;
          case (op)
            `SSTT_OP_SHIFT_RIGHT: begin
              if (!cnt_neg) begin
                stat_bad <= 1'b1;
              end else begin
                result <= shf_res;
                dest <= (dest & ~mask_sz(32'hFFFFFFFF, size)) | shf_res;
                flag_control_word[`SSTT_FLAG_C] <= shf[0];
                flag_control_word[`SSTT_FLAG_Z] <= (shf_res == 32'h00000000);
                flag_control_word[`SSTT_FLAG_S] <= msb_sz(shf_res, size);
              end
            end
            `SSTT_OP_SUBTRACT: begin
              result <= sub_res;
              dest <= (dest & ~mask_sz(32'hFFFFFFFF, size)) | sub_res;
              flag_control_word[`SSTT_FLAG_C] <= sub_borrow;
              flag_control_word[`SSTT_FLAG_Z] <= (sub_res == 32'h00000000);
              flag_control_word[`SSTT_FLAG_S] <= msb_sz(sub_res, size);
              flag_control_word[`SSTT_FLAG_PV] <= sub_ovf;
              stat_ovf <= sub_ovf;
              o_ovf_trap <= sub_ovf;
              if (size == `SSTT_SIZE_BYTE) begin
                flag_control_word[`SSTT_FLAG_D] <= 1'b1;
                flag_control_word[`SSTT_FLAG_H] <= nib[4];
              end
            end
            `SSTT_OP_COND_BIT_SET: begin
              result <= dest | {31'h00000000, cc_ok};
              dest[0] <= dest[0] | cc_ok;
            end
            `SSTT_OP_LOGICAL_TEST: begin
              result <= opd;
              flag_control_word[`SSTT_FLAG_Z] <= (opd == 32'h00000000);
              flag_control_word[`SSTT_FLAG_S] <= msb_sz(opd, size);
              if (size == `SSTT_SIZE_BYTE) begin
                flag_control_word[`SSTT_FLAG_PV] <= ~^opd[7:0];
              end
            end
            `SSTT_OP_ARITH_TEST: begin
              result <= opd;
              flag_control_word[`SSTT_FLAG_C] <= 1'b0;
              flag_control_word[`SSTT_FLAG_PV] <= 1'b0;
              flag_control_word[`SSTT_FLAG_Z] <= (opd == 32'h00000000);
              flag_control_word[`SSTT_FLAG_S] <= msb_sz(opd, size);
            end
            `SSTT_OP_COND_TRAP: begin
              if (cc_ok) begin
                o_mem_req <= 1'b1;
                o_mem_we <= 1'b1;
                o_mem_addr <= trap_sp;
                o_mem_wdata <= {16'h0000, flag_control_word};
                o_mem_size <= `SSTT_SIZE_WORD;
                state <= ST_TP_PUSH_FCW;
              end
            end
            `SSTT_OP_TRANSLATE: begin
              if (ext[11:8] == 4'h0 || ext[7:4] == 4'h0) begin
                stat_bad <= 1'b1;
              end else begin
                o_mem_req <= 1'b1;
                o_mem_we <= 1'b0;
                o_mem_addr <= addr_add(dest, 32'h00000000, mode);
                o_mem_size <= `SSTT_SIZE_BYTE;
                state <= ST_TR_RD_TGT;
              end
            end
            default: stat_bad <= 1'b1;
          endcase
        end
        ST_TR_RD_TGT: begin
          if (i_mem_ack) begin
            tgt_byte <= i_mem_rdata[7:0];
            o_mem_addr <= addr_add(src, {24'h000000, i_mem_rdata[7:0]}, mode);
            state <= ST_TR_RD_TAB;
          end
        end
        ST_TR_RD_TAB: begin
          if (i_mem_ack) begin
            xlat_byte <= i_mem_rdata[7:0];
            o_mem_we <= 1'b1;
            o_mem_addr <= addr_add(dest, 32'h00000000, mode);
            o_mem_wdata <= {24'h000000, i_mem_rdata[7:0]};
            state <= ST_TR_WR;
          end
        end
        ST_TR_WR: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            result <= {16'h0000, tgt_byte, xlat_byte};
            dest <= dest_dec;
            count <= count_dec;
            flag_control_word[`SSTT_FLAG_PV] <= (count_dec == 16'h0000);
            state <= ST_IDLE;
          end
        end
        ST_TP_PUSH_FCW: begin
          if (i_mem_ack) begin
            o_mem_addr <= trap_sp + 32'h00000002;
            o_mem_wdata <= pc;
            o_mem_size <= `SSTT_SIZE_LONG;
            state <= ST_TP_PUSH_PC;
          end
        end
        ST_TP_PUSH_PC: begin
          if (i_mem_ack) begin
            o_mem_addr <= ins_sp;
            o_mem_wdata <= {16'h0000, ext[15:0]};
            o_mem_size <= `SSTT_SIZE_WORD;
            state <= ST_TP_PUSH_INS;
          end
        end
        ST_TP_PUSH_INS: begin
          if (i_mem_ack) begin
            o_mem_we <= 1'b0;
            o_mem_addr <= TRAP_PS_ADDR;
            o_mem_size <= `SSTT_SIZE_WORD;
            state <= ST_TP_LOAD;
          end
        end
        ST_TP_LOAD: begin
          if (i_mem_ack) begin
            o_mem_req <= 1'b0;
            flag_control_word <= i_mem_rdata[15:0];
            sp <= ins_sp;
            stat_trap <= 1'b1;
            o_trap_taken <= 1'b1;
            o_trap_cause <= ext[7:4];
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule

// *** dv/sstt_checker.sv ***
// Port-level checks of the datapath
`timescale 1ns/1ps
module sstt_checker (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Register bus
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  // Memory path
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [31:0] o_mem_addr,
  input wire logic [1:0] o_mem_size,
  input wire logic i_mem_ack,
  // Status
  input wire logic o_busy,
  input wire logic o_ovf_trap,
  input wire logic o_trap_taken,
  input wire logic [3:0] o_trap_cause
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_mem_pending;
    o_mem_req && !i_mem_ack;
  endsequence
  sequence s_mem_held;
    o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we) && $stable(o_mem_size);
  endsequence
  property p_mem_hold;
    s_mem_pending |=> s_mem_held;
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request moved before its answer");
  property p_mem_busy;
    o_mem_req |-> o_busy;
  endproperty
  a_mem_busy: assert property (p_mem_busy) else $error("memory access outside an operation");
  property p_wait_idle;
    !i_avs_read && !i_avs_write |-> !o_avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("wait asserted with no request");
  property p_read_answer;
    $rose(i_avs_read) |=> !o_avs_waitrequest;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read not answered in one cycle");
  property p_write_stall;
    i_avs_write && o_busy |-> o_avs_waitrequest;
  endproperty
  a_write_stall: assert property (p_write_stall) else $error("write accepted while busy");
  property p_ovf_pulse;
    o_ovf_trap |-> $past(o_busy) ##1 !o_ovf_trap;
  endproperty
  a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse malformed");
  property p_trap_pulse;
    o_trap_taken |-> $past(o_busy) ##1 !o_trap_taken;
  endproperty
  a_trap_pulse: assert property (p_trap_pulse) else $error("trap pulse malformed");
  property p_cause_hold;
    $changed(o_trap_cause) |-> o_trap_taken;
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("trap cause moved without a trap");
  property p_busy_bound;
    $rose(o_busy) |-> ##[1:200] !o_busy;
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("operation never ended");
endmodule
////////////////////////////////////////////////////////////////////////////
bind sstt_core sstt_checker i_sstt_checker (.i_clock(i_clock), .i_rst(i_rst), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write), .o_avs_waitrequest(o_avs_waitrequest), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_addr(o_mem_addr), .o_mem_size(o_mem_size), .i_mem_ack(i_mem_ack), .o_busy(o_busy),
  .o_ovf_trap(o_ovf_trap), .o_trap_taken(o_trap_taken), .o_trap_cause(o_trap_cause));

// *** dv/sstt_mem_model.sv ***
// Memory path model answering byte, word and long accesses
`timescale 1ns/1ps
module sstt_mem_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst,
  // Request
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [1:0] i_size,
  input wire logic i_slow,
  // Answer
  output logic o_ack,
  output logic [31:0] o_rdata
);
  logic [7:0] mem [0:65535];
  logic [31:0] wr_addr [0:15];
  logic [31:0] wr_data [0:15];
  logic [1:0] wr_size [0:15];
  int wr_cnt = 0;
  int wait_n = 0;
  wire [15:0] a = i_addr[15:0];
  // Read data is junk outside the answer cycle, so a late sample shows up
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_ack <= 1'b0;
      o_rdata <= 32'h00000000;
      wait_n <= 0;
    end else if (i_req && !o_ack && wait_n < (i_slow ? 3 : 0)) begin
      wait_n <= wait_n + 1;
      o_rdata <= ~o_rdata;
    end else if (i_req && !o_ack) begin
      wait_n <= 0;
      o_ack <= 1'b1;
      o_rdata <= ~o_rdata;
      if (i_we) begin
        mem[a] <= i_wdata[7:0];
        if (i_size != 2'h0) mem[a + 16'h1] <= i_wdata[15:8];
        if (i_size == 2'h2) mem[a + 16'h2] <= i_wdata[23:16];
        if (i_size == 2'h2) mem[a + 16'h3] <= i_wdata[31:24];
        wr_addr[wr_cnt] <= i_addr;
        wr_data[wr_cnt] <= i_wdata;
        wr_size[wr_cnt] <= i_size;
        wr_cnt <= wr_cnt + 1;
      end else begin
        o_rdata <= {(i_size == 2'h2) ? {mem[a + 16'h3], mem[a + 16'h2]} : 16'h0000,
          (i_size != 2'h0) ? mem[a + 16'h1] : 8'h00, mem[a]};
      end
    end else begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
    end
  end
endmodule

// *** dv/shift_sub_test_trap_translate_tb_top.sv ***
// Self-checking bench for the datapath
`timescale 1ns/1ps
`include "sstt_map.vh"
module shift_sub_test_trap_translate_tb_top;
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic slow = 1'b0;
  wire [31:0] avs_readdata, mem_addr, mem_wdata, mem_rdata;
  wire avs_waitrequest, mem_req, mem_we, mem_ack, busy, ovf_trap, trap_taken;
  wire [1:0] mem_size;
  wire [3:0] trap_cause;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  int ovf_seen = 0;
  sstt_core #(.TRAP_PS_ADDR(32'h00000200)) i_sstt_core (.i_clock(i_clock), .i_rst(i_rst),
    .i_avs_address(avs_address), .i_avs_read(avs_read), .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .i_avs_byteenable(4'hF), .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .o_mem_req(mem_req), .o_mem_we(mem_we), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
    .o_mem_size(mem_size), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata), .o_busy(busy),
    .o_ovf_trap(ovf_trap), .o_trap_taken(trap_taken), .o_trap_cause(trap_cause));
  sstt_mem_model i_sstt_mem_model (.i_clock(i_clock), .i_rst(i_rst), .i_req(mem_req), .i_we(mem_we),
    .i_addr(mem_addr), .i_wdata(mem_wdata), .i_size(mem_size), .i_slow(slow), .o_ack(mem_ack), .o_rdata(mem_rdata));
  initial begin
    forever #2.5 i_clock = ~i_clock;
  end
  // Hang guard: the whole run needs well under this many cycles
  always @(posedge i_clock) begin
    cycles++;
    if (ovf_trap === 1'b1) ovf_seen++;
    if (cycles == 20000) begin
      num_errors++;
      $display("CHECK FAILED at %0t: timeout", $time);
      end_sim();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge i_clock); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge i_clock); while (avs_waitrequest !== 1'b0);
    chk(avs_readdata, exp, $sformatf("reg %h", a));
    avs_read <= 1'b0;
    @(posedge i_clock);
  endtask
  task automatic set(input logic [31:0] d, input logic [31:0] s, input logic [31:0] e, input logic [31:0] f);
    wr(`SSTT_OFS_DEST, d);
    wr(`SSTT_OFS_SRC, s);
    wr(`SSTT_OFS_EXT, e);
    wr(`SSTT_OFS_FCW, f);
  endtask
  // Writing the control word starts the operation; wait until it is over
  task automatic op(input logic [3:0] code, input logic [1:0] sz, input logic [3:0] cc);
    wr(`SSTT_OFS_CTRL, {16'h0000, cc, 2'b00, `SSTT_MODE_COMPACT, 2'b00, sz, code});
    do @(posedge i_clock); while (busy !== 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdc(`SSTT_OFS_DEST, 32'h00000000);
    rdc(`SSTT_OFS_STATUS, 32'h00000000);
    wr(8'h40, 32'hFFFFFFFF);
    rdc(8'h40, 32'h00000000);
    rdc(8'h05, 32'h00000000);
  endtask
  task automatic t_shift();
    set(32'h12345681, 32'h0, 32'h000000FF, 32'h0);
    op(`SSTT_OP_SHIFT_RIGHT, `SSTT_SIZE_BYTE, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'h12345640);
    rdc(`SSTT_OFS_FCW, 32'h00000080);
    set(32'hAAAAF0F8, 32'h0, 32'h0000FFFC, 32'h0);
    op(`SSTT_OP_SHIFT_RIGHT, `SSTT_SIZE_WORD, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'hAAAA0F0F);
    set(32'h80000000, 32'h0, 32'h0000FFE0, 32'h0);
    op(`SSTT_OP_SHIFT_RIGHT, `SSTT_SIZE_LONG, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'h00000000);
    rdc(`SSTT_OFS_FCW, 32'h000000C0);
    set(32'h00000055, 32'h0, 32'h00000003, 32'h0);
    op(`SSTT_OP_SHIFT_RIGHT, `SSTT_SIZE_LONG, 4'h0);
    rdc(`SSTT_OFS_STATUS, 32'h00000008);
    rdc(`SSTT_OFS_DEST, 32'h00000055);
  endtask
  task automatic t_sub();
    set(32'h00000080, 32'h00000001, 32'h0, 32'h0);
    op(`SSTT_OP_SUBTRACT, `SSTT_SIZE_BYTE, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'h0000007F);
    rdc(`SSTT_OFS_SRC, 32'h00000001);
    rdc(`SSTT_OFS_FCW, 32'h0000001C);
    rdc(`SSTT_OFS_STATUS, 32'h00000002);
    chk(ovf_seen, 1, "overflow pulses");
    set(32'h00000001, 32'h00000002, 32'h0, 32'h0000000C);
    op(`SSTT_OP_SUBTRACT, `SSTT_SIZE_WORD, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'h0000FFFF);
    rdc(`SSTT_OFS_FCW, 32'h000000AC);
  endtask
  task automatic t_bit_test();
    set(32'h00000010, 32'h0, 32'h0, 32'h00000040);
    op(`SSTT_OP_COND_BIT_SET, `SSTT_SIZE_LONG, 4'h6);
    rdc(`SSTT_OFS_DEST, 32'h00000011);
    rdc(`SSTT_OFS_FCW, 32'h00000040);
    set(32'h00000010, 32'h0, 32'h0, 32'h00000040);
    op(`SSTT_OP_COND_BIT_SET, `SSTT_SIZE_LONG, 4'hE);
    rdc(`SSTT_OFS_DEST, 32'h00000010);
    set(32'h00000003, 32'h0, 32'h0, 32'h0000008C);
    op(`SSTT_OP_LOGICAL_TEST, `SSTT_SIZE_BYTE, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'h00000003);
    rdc(`SSTT_OFS_FCW, 32'h0000009C);
    set(32'h00008000, 32'h0, 32'h0, 32'h00000010);
    op(`SSTT_OP_LOGICAL_TEST, `SSTT_SIZE_WORD, 4'h0);
    rdc(`SSTT_OFS_FCW, 32'h00000030);
    set(32'h80000000, 32'h0, 32'h0, 32'h0000009C);
    op(`SSTT_OP_ARITH_TEST, `SSTT_SIZE_LONG, 4'h0);
    rdc(`SSTT_OFS_FCW, 32'h0000002C);
  endtask
  task automatic t_trap();
    i_sstt_mem_model.mem[16'h0200] = 8'h44;
    i_sstt_mem_model.mem[16'h0201] = 8'h44;
    wr(`SSTT_OFS_SP, 32'h00000100);
    wr(`SSTT_OFS_PC, 32'h12345678);
    set(32'h0, 32'h0, 32'h000000A0, 32'h00000040);
    op(`SSTT_OP_COND_TRAP, `SSTT_SIZE_WORD, 4'h6);
    rdc(`SSTT_OFS_SP, 32'h000000F8);
    rdc(`SSTT_OFS_FCW, 32'h00004444);
    rdc(`SSTT_OFS_STATUS, 32'h000000A4);
    chk(trap_cause, 32'hA, "cause pins");
    chk(i_sstt_mem_model.wr_addr[0], 32'h000000FA, "status push");
    chk(i_sstt_mem_model.wr_data[1], 32'h12345678, "pc push");
    chk({i_sstt_mem_model.wr_data[2][15:0], 14'h0000, i_sstt_mem_model.wr_size[2]}, 32'h00A00001, "insn");
    chk(i_sstt_mem_model.wr_addr[2], 32'h000000F8, "insn push");
    op(`SSTT_OP_COND_TRAP, `SSTT_SIZE_WORD, 4'hE);
    rdc(`SSTT_OFS_SP, 32'h000000F8);
    chk(i_sstt_mem_model.wr_cnt, 3, "no push on false");
  endtask
  task automatic t_translate();
    i_sstt_mem_model.mem[16'h4001] = 8'h03;
    i_sstt_mem_model.mem[16'h1003] = 8'hAA;
    i_sstt_mem_model.mem[16'h4000] = 8'hFF;
    i_sstt_mem_model.mem[16'h10FF] = 8'h5A;
    wr(`SSTT_OFS_COUNT, 32'h00000002);
    set(32'h00004001, 32'h00001000, 32'h00000C90, 32'h00000090);
    op(`SSTT_OP_TRANSLATE, `SSTT_SIZE_BYTE, 4'h0);
    chk(i_sstt_mem_model.mem[16'h4001], 32'hAA, "translated");
    rdc(`SSTT_OFS_DEST, 32'h00004000);
    rdc(`SSTT_OFS_SRC, 32'h00001000);
    rdc(`SSTT_OFS_COUNT, 32'h00000001);
    rdc(`SSTT_OFS_FCW, 32'h00000080);
    rdc(`SSTT_OFS_RESULT, 32'h000003AA);
    slow <= 1'b1;
    op(`SSTT_OP_TRANSLATE, `SSTT_SIZE_BYTE, 4'h0);
    chk(i_sstt_mem_model.mem[16'h4000], 32'h5A, "top entry");
    rdc(`SSTT_OFS_COUNT, 32'h00000000);
    rdc(`SSTT_OFS_FCW, 32'h00000090);
    wr(`SSTT_OFS_EXT, 32'h00000000);
    op(`SSTT_OP_TRANSLATE, `SSTT_SIZE_BYTE, 4'h0);
    rdc(`SSTT_OFS_DEST, 32'h00003FFF);
    chk(i_sstt_mem_model.wr_cnt, 5, "refused no write");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_shift();
    t_sub();
    t_bit_test();
    t_trap();
    t_translate();
    end_sim();
  end
endmodule
